// file: hdl/acs_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge mclk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule
`default_nettype wire

// file: hdl/acs_sequencer.sv
// Conversion sequencer: modes, result buffer and data-ready output.
// Assumes an I2C command decoder on mclk that pulses cmd_valid at the
// eighth falling clock edge of the command byte, and a filter source
// delivering samples through sample_valid/sample_ready.
//
// How it works
// R1 - Hold ready high two modulator periods minimum
// R2 - Read command drives ready high after two
// R3 - One config register, six link commands
// R4 - Exactly two modes: single-shot, continuous
// R5 - Single-shot: one conversion, buffer, then idle
// R6 - Continuous: restart conversion on each completion
// R7 - Reads return whole latest result, atomic
// R8 - Result is sixteen-bit code after gain
// R9 - Gain setting selects one or four
// R10 - Modulator clock is oscillator divided by four
// R11 - Command latched at eighth falling edge
// R12 - Continuous first conversion after 28.5 oscillator periods
// R13 - Ready low when new result buffered
// R14 - Controller reads after seeing ready low
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int CONV_MOD = `ACS_CONV_MOD
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [7:0] cmd_config,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [15:0] sample_data,
    output logic [15:0] result_data,
    output logic [7:0] config_data,
    output logic result_ready_n,
    output logic mode_continuous,
    output logic gain_four,
    output logic low_power,
    output logic converting
);
    localparam int MOD_CYC = `ACS_MOD_CYC;
    localparam int START_CYC = `ACS_START_CYC;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    acs_cmd_t cmd;
    logic cmd_start;
    logic cmd_read;
    logic cmd_reset;
    logic cmd_pd;
    logic cmd_wcfg;
    assign cmd = acs_cmd_t'(cmd_code);
    // Commands arrive as pulses already latched on the eighth falling edge [R11]
    assign cmd_start = cmd_valid && (cmd == acs_cmd_start);
    assign cmd_read = cmd_valid && (cmd == acs_cmd_read_result);
    assign cmd_reset = cmd_valid && (cmd == acs_cmd_reset);
    assign cmd_pd = cmd_valid && (cmd == acs_cmd_powerdown);
    assign cmd_wcfg = cmd_valid && (cmd == acs_cmd_write_config);

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    logic [7:0] config_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            config_reg <= `ACS_CFG_RESET;
        end else if (cmd_reset) begin
            config_reg <= `ACS_CFG_RESET;
        end else if (cmd_wcfg) begin
            config_reg <= cmd_config; // [R3]
        end
    end
    assign config_data = config_reg;
    // Bit 1 picks continuous mode, bit 4 picks gain of four
    assign mode_continuous = config_reg[`ACS_CFG_MODE_BIT]; // [R4]
    assign gain_four = config_reg[`ACS_CFG_GAIN_BIT]; // [R9]

    // ------------------------------------------------------------
    // Modulator period enable
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic mod_tick;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 8'h00;
        end else if (div_cnt == 8'(MOD_CYC - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign mod_tick = (div_cnt == 8'(MOD_CYC - 1)); // [R10]

    // ------------------------------------------------------------
    // Conversion state machine
    // ------------------------------------------------------------
    acs_state_t state;
    logic [15:0] tmr;
    logic conv_done;
    logic [15:0] fifo_data;
    logic fifo_valid;
    logic fifo_in_ready;

    assign conv_done = (state == acs_st_convert) && mod_tick && (tmr == 16'h0000);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= acs_st_idle;
            tmr <= 16'h0000;
        end else if (cmd_reset || cmd_pd) begin
            state <= acs_st_idle;
            tmr <= 16'h0000;
        end else if (cmd_start) begin
            state <= acs_st_start_wait;
            tmr <= 16'(START_CYC - 1); // [R12]
        end else begin
            unique case (state)
                acs_st_idle: begin
                    tmr <= 16'h0000;
                end
                acs_st_start_wait: begin
                    if (tmr == 16'h0000) begin
                        state <= acs_st_convert;
                        tmr <= 16'(CONV_MOD - 1);
                    end else begin
                        tmr <= tmr - 16'h0001;
                    end
                end
                acs_st_convert: begin
                    if (conv_done && fifo_valid) begin
                        if (mode_continuous) begin
                            tmr <= 16'(CONV_MOD - 1); // [R6]
                        end else begin
                            state <= acs_st_idle; // [R5]
                        end
                    end else if (mod_tick && tmr != 16'h0000) begin
                        tmr <= tmr - 16'h0001;
                    end
                end
            endcase
        end
    end
    assign converting = (state != acs_st_idle);
    assign low_power = (state == acs_st_idle);

    // ------------------------------------------------------------
    // Sample path through the FIFO
    // ------------------------------------------------------------
    logic fifo_pop;
    assign fifo_pop = conv_done && fifo_valid;
    acs_fifo #(
        .WIDTH(`ACS_RES_W),
        .DEPTH(`ACS_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(sample_valid),
        .in_ready(fifo_in_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(conv_done),
        .out_data(fifo_data)
    );
    assign sample_ready = fifo_in_ready;

    // Whole word copied in one edge so a read never sees a mix [R7]
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result_data <= 16'h0000;
        end else if (fifo_pop) begin
            result_data <= fifo_data; // [R8]
        end
    end

    // ------------------------------------------------------------
    // Data-ready output
    // ------------------------------------------------------------
    logic [1:0] rd_dly;
    logic rd_pend;
    logic [1:0] high_cnt;
    logic new_pend;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_pend <= 1'b0;
            rd_dly <= 2'h0;
        end else if (cmd_read) begin
            rd_pend <= 1'b1;
            rd_dly <= 2'(`ACS_RD_DLY_MOD);
        end else if (rd_pend && mod_tick) begin
            if (rd_dly == 2'h1) begin
                rd_pend <= 1'b0;
            end
            rd_dly <= rd_dly - 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result_ready_n <= 1'b1;
            high_cnt <= 2'(`ACS_RDY_HIGH_MOD);
            new_pend <= 1'b0;
        end else begin
            // New result wins over a pending clear of the flag
            if (fifo_pop) begin
                new_pend <= 1'b1;
            end else if (!result_ready_n) begin
                new_pend <= 1'b0;
            end
            if (!result_ready_n) begin
                high_cnt <= 2'h0;
                if ((rd_pend && mod_tick && rd_dly == 2'h1) || fifo_pop) begin
                    result_ready_n <= 1'b1; // [R2]
                end
            end else begin
                if (mod_tick && high_cnt != 2'(`ACS_RDY_HIGH_MOD)) begin
                    high_cnt <= high_cnt + 2'h1;
                end
                if ((new_pend || fifo_pop) && high_cnt == 2'(`ACS_RDY_HIGH_MOD)) begin
                    result_ready_n <= 1'b0; // [R1] [R13]
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: pkg/acs_defs.svh
// Timing constants and fixed values for the conversion sequencer.
// Assumes a 20 MHz mclk; included by bare name.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_MCLK_HZ 20000000
`define ACS_OSC_HZ 1024000
`define ACS_MOD_DIV 4
// Modulator clock, 256 kHz
`define ACS_MOD_HZ (`ACS_OSC_HZ / `ACS_MOD_DIV)
// Mclk cycles per modulator period, rounded down for the enable divider
`define ACS_MOD_CYC (`ACS_MCLK_HZ / `ACS_MOD_HZ)
// Data-ready high time in modulator periods, least
`define ACS_RDY_HIGH_MOD 2
// Read-command to data-ready rising, modulator periods, typical
`define ACS_RD_DLY_MOD 2
// Start delay in tenths of an oscillator period (28.5)
`define ACS_START_DLY_TENTHS 285
// Start delay in mclk cycles, least time so rounded up; kHz keeps the product in 32 bits
`define ACS_START_CYC ((`ACS_START_DLY_TENTHS * (`ACS_MCLK_HZ / 1000) + (`ACS_OSC_HZ / 1000) * 10 - 1) / ((`ACS_OSC_HZ / 1000) * 10))
// Conversion length in modulator periods (default data rate)
`define ACS_CONV_MOD 12798
`define ACS_RES_W 16
`define ACS_FIFO_DEPTH 32
`define ACS_CMD_W 3
// Configuration byte: reset value and field positions
`define ACS_CFG_RESET 8'h00
`define ACS_CFG_MODE_BIT 1
`define ACS_CFG_GAIN_BIT 4

`endif

// file: pkg/acs_pkg.sv
// Types for the conversion sequencer.
// Assumes nothing beyond the defs header.
package acs_pkg;
    typedef enum logic [2:0] {
        acs_cmd_reset,
        acs_cmd_start,
        acs_cmd_powerdown,
        acs_cmd_read_result,
        acs_cmd_read_config,
        acs_cmd_write_config
    } acs_cmd_t;

    typedef enum logic {
        acs_mode_single,
        acs_mode_continuous
    } acs_mode_t;

    typedef enum logic [1:0] {
        acs_st_idle,
        acs_st_start_wait,
        acs_st_convert
    } acs_state_t;
endpackage

// file: sim/acs_ctrl_model.sv
// Link controller model: issues commands and reads results.
// Assumes commands arrive already decoded as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module acs_ctrl_model (
    input wire logic mclk,
    input wire logic result_ready_n,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic [7:0] cmd_config
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 3'h7;
        cmd_config = 8'h00;
    end
    // ----------------
    // Command pulse
    // ----------------
    task automatic send(input logic [2:0] code, input logic [7:0] cfg);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_config = cfg;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_code = ~code;
        cmd_config = ~cfg;
    endtask
    task automatic read_result(output bit seen);
        int n;
        seen = 1'b0;
        for (n = 0; n < 2000 && !seen; n++) begin
            @(negedge mclk);
            seen = (result_ready_n === 1'b0);
        end
        if (seen) send(3'h3, 8'h00);
    endtask
endmodule
`default_nettype wire

// file: sim/acs_sequencer_properties.sv
// Port checker for the conversion sequencer.
// Assumes a single mclk domain; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_properties
    import acs_pkg::*;
#(
    parameter int CONV_MOD = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [7:0] cmd_config,
    input wire logic [15:0] result_data,
    input wire logic [7:0] config_data,
    input wire logic result_ready_n,
    input wire logic mode_continuous,
    input wire logic gain_four,
    input wire logic low_power,
    input wire logic converting
);
    logic [7:0] high_cnt;
    logic [7:0] last_cfg;
    // ----------------
    // Last configuration byte written
    // ----------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            last_cfg <= 8'h00;
        end else if (cmd_valid && cmd_code == 3'h0) begin
            last_cfg <= 8'h00;
        end else if (cmd_valid && cmd_code == 3'h5) begin
            last_cfg <= cmd_config;
        end
    end
    // ----------------
    // Cycles spent high
    // ----------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            high_cnt <= 8'h00;
        end else if (!result_ready_n) begin
            high_cnt <= 8'h00;
        end else if (high_cnt != 8'hff) begin
            high_cnt <= high_cnt + 8'h01;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_ready_high_min: assert property ($fell(result_ready_n) |-> high_cnt >= 8'h9d)
        else $error("ready low again too soon");
    a_read_rises: assert property (cmd_valid && cmd_code == 3'h3 && !result_ready_n |-> ##[1:160] result_ready_n)
        else $error("ready not released after read");
    a_config_write: assert property (cmd_valid && cmd_code == 3'h5 |=> config_data == $past(cmd_config))
        else $error("config byte not taken");
    a_mode_bit: assert property (mode_continuous == last_cfg[1])
        else $error("mode does not follow config");
    a_start_leaves: assert property (cmd_valid && cmd_code == 3'h1 && low_power |=> ##[0:1] converting)
        else $error("start ignored");
    a_single_idle: assert property ($changed(result_data) && !mode_continuous |-> ##[0:2] low_power)
        else $error("single-shot did not idle");
    a_cont_again: assert property ($changed(result_data) && mode_continuous |-> converting)
        else $error("continuous did not restart");
    a_result_whole: assert property ($changed(result_data) |-> $past(converting))
        else $error("result changed outside a conversion");
    a_gain_bit: assert property (gain_four == last_cfg[4])
        else $error("gain does not follow config");
    a_reset_clears: assert property (cmd_valid && cmd_code == 3'h0 |=> config_data == 8'h00 && low_power)
        else $error("reset command did not clear");
    a_new_falls: assert property ($changed(result_data) |-> ##[0:160] !result_ready_n)
        else $error("ready not low after new result");
    c_single: cover property ($fell(result_ready_n) && !mode_continuous);
    c_cont: cover property ($fell(result_ready_n) && mode_continuous);
    c_read: cover property (cmd_valid && cmd_code == 3'h3);
endmodule
bind acs_sequencer acs_sequencer_properties #(.CONV_MOD(CONV_MOD)) u_props (.mclk(mclk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_config(cmd_config), .result_data(result_data),
    .config_data(config_data), .result_ready_n(result_ready_n), .mode_continuous(mode_continuous),
    .gain_four(gain_four), .low_power(low_power), .converting(converting));
`default_nettype wire

// file: sim/acs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes CONV_MOD is shortened to 4 for the run.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module acs_sequencer_tb;
    import acs_pkg::*;
    logic mclk, rstn, cmd_valid, sample_valid, sample_ready, result_ready_n, mode_continuous, gain_four;
    logic low_power, converting;
    logic [2:0] cmd_code;
    logic [7:0] cmd_config, config_data;
    logic [15:0] sample_data, result_data, d;
    logic [15:0] q[$];
    int n_mismatch = 0, n_tests = 0, seed = 69, cyc = 0, n, i;
    bit ok;
    acs_sequencer #(.CONV_MOD(4)) dut (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_config(cmd_config), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .result_data(result_data), .config_data(config_data),
        .result_ready_n(result_ready_n), .mode_continuous(mode_continuous), .gain_four(gain_four),
        .low_power(low_power), .converting(converting));
    acs_ctrl_model ctl (.mclk(mclk), .result_ready_n(result_ready_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_config(cmd_config));
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [15:0] cfg_bits(input logic [7:0] c);
        return {14'h0, c[4], c[1]};
    endfunction
    // Earliest or latest first result after start, four-tick conversions
    function automatic int conv_window(input bit hi);
        return `ACS_START_CYC + (hi ? 4 * `ACS_MOD_CYC : 1 + 3 * `ACS_MOD_CYC);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic push(input logic [15:0] v, output bit taken);
        @(negedge mclk);
        sample_valid = 1'b1;
        sample_data = v;
        taken = sample_ready;
        @(negedge mclk);
        sample_valid = 1'b0;
        sample_data = ~v;
    endtask
    task automatic read_and_release();
        ctl.read_result(ok);
        check(16'(ok), 16'h1);
        check(result_data, q.pop_front());
        for (n = 0; n < 300 && result_ready_n !== 1'b1; n++) @(negedge mclk);
        check(16'(n <= 160), 16'h1);
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        rstn = 1'b0;
        sample_valid = 1'b0;
        sample_data = 16'h0000;
        repeat (10) @(negedge mclk);
        check({13'h0, result_ready_n, low_power, converting}, 16'h6);
        rstn = 1'b1;
        ctl.send(3'h5, 8'h10);
        check(cfg_bits(8'h10), {14'h0, gain_four, mode_continuous});
        d = 16'($random(seed));
        push(d, ok);
        q.push_back(d);
        ctl.send(3'h1, 8'h00);
        read_and_release();
        check(16'(low_power), 16'h1);
        $display("single-shot test done");
        ok = 1'b1;
        for (i = 0; ok && i < 40; i++) begin
            d = (i == 0) ? 16'hffff : ((i == 1) ? 16'h0000 : 16'($random(seed)));
            push(d, ok);
            if (ok) q.push_back(d);
        end
        check(16'(q.size()), 16'h20);
        check(16'(low_power), 16'h1);
        ctl.send(3'h5, 8'h02);
        check(cfg_bits(8'h02), {14'h0, gain_four, mode_continuous});
        ctl.send(3'h1, 8'h00);
        for (n = 0; n < 2000 && result_ready_n !== 1'b0; n++) @(negedge mclk);
        check(16'(n >= conv_window(1'b0) && n <= conv_window(1'b1)), 16'h1);
        for (i = 0; i < 32; i++) read_and_release();
        check(16'(sample_ready), 16'h1);
        $display("continuous drain test done");
        ctl.send(3'h2, 8'h00);
        repeat (2) @(negedge mclk);
        check(16'(low_power), 16'h1);
        ctl.send(3'h7, 8'hff);
        check(16'(config_data), 16'h2);
        ctl.send(3'h0, 8'h00);
        check(16'(config_data), 16'h0);
        check(16'(low_power), 16'h1);
        $display("command test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
